// [logic/dsw_status_word.sv]
// drive status word generator with warning capture and remote gating
//
// Summary of operation
// - state in bits 0-3, 5, 6; rest flags
// - bit 4 follows power stage high voltage
// - bit 5 low during quick stop reaction, but held high in ready, switched on and operation enabled
// - illegal control word sets warning, code kept
// - bit 8 set at load torque threshold
// - bit 9 remote: commands executed only then
// - local mode still grants parameter access, transmits
// - bit 10 setpoint reached, re-evaluated on change
// - quick stop option 5/6 done at standstill sets bit 10
// - halt standstill also sets bit 10
// - bit 12 setpoint ack, homing attained, or follows command in the cyclic modes
// - bit 13 following, homing or sequence error
// - bit 14 sequential motion started
// - bit 15 sequential motion completed
// - not ready: bit 6 low, low nibble 0000
// - switch on disabled: bit 6 high, 0000
// - ready to switch on: x01x 0001
// - switched on: x01x 0011
// - operation enabled: x01x 0111
// - quick stop active: x00x 0111
// - fault reaction active: x0xx 1111
// - fault: x0xx 1000
// - word is read only, 16 bits unsigned
`timescale 1ns/10ps
module dsw_status_word
  import dsw_pkg::*;
(
  input  wire logic        clk_sys,       // 50 MHz system clock
  input  wire logic        sys_rst,       // synchronous reset, active high
  input  wire logic        ce,            // clock enable, freezes all state
  input  wire dsw_state_t  drive_state,   // present drive state
  input  wire dsw_mode_t   op_mode,       // active operating mode
  input  wire logic        hv_on,         // high voltage on power stage
  input  wire logic        qs_busy,       // quick stop reaction running
  input  wire logic        illegal_cw,    // illegal control word pulse
  input  wire logic [15:0] illegal_code,  // cause code for the warning
  input  wire logic        tx_strobe,     // status word sent on the bus
  input  wire logic        warn_clr,      // warning acknowledge pulse
  input  wire logic [15:0] load_torque,   // measured load torque
  input  wire logic [15:0] torque_limit,  // configured torque threshold
  input  wire logic        remote_en,     // network control selected
  input  wire logic        cmd_valid,     // command message pending
  input  wire logic        sdo_req,       // parameter access request
  input  wire logic        setpoint_hit,  // mode setpoint reached
  input  wire logic        target_chg,    // target value changed pulse
  input  wire logic [15:0] qs_option,     // quick stop option code
  input  wire logic        qs_done,       // quick stop finished
  input  wire logic        standstill,    // motor at standstill
  input  wire logic        halt_stopped,  // halt brought drive to stop
  input  wire logic        limit_active,  // internal limit active
  input  wire logic        sp_ack,        // setpoint acknowledge
  input  wire logic        follows_cmd,   // drive follows command value
  input  wire logic        homing_done,   // homing attained
  input  wire logic        homing_err,    // homing error
  input  wire logic        follow_err,    // following error
  input  wire logic        seq_err,       // motion sequence error
  input  wire logic        seq_started,   // sequential motion started
  input  wire logic        seq_finished,  // sequential motion completed
  output logic [15:0]      status_word,   // read-only status word
  output logic [15:0]      warn_code,     // cause of the last warning
  output logic             cmd_accept,    // command taken for execution
  output logic             sdo_grant,     // parameter access granted
  output logic             tx_allow       // process data may be sent
);

  // all state of the block
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] code;
    logic        warn_sent;
    logic        tgt_hit;
  } dsw_regs_t;

  localparam dsw_regs_t DSW_REGS_RST = '{
    word: DSW_WORD_RST, code: DSW_CODE_RST, warn_sent: 1'b0, tgt_hit: 1'b0};

  dsw_regs_t   r;
  dsw_regs_t   next_r;
  logic [3:0]  state_low;
  logic        qs_bit;
  logic        sod_bit;
  logic        tgt_set;
  logic        warn_now;

  // true when the active mode is one of the given pair
  function automatic logic dsw_mode_is(input dsw_mode_t m, input dsw_mode_t a,
                                       input dsw_mode_t b);
    dsw_mode_is = (m == a) || (m == b);
  endfunction

  // state bits come from one encoder so they never mix two states
  dsw_state_enc u_enc (
    .drive_state (drive_state),
    .qs_busy     (qs_busy),
    .state_low   (state_low),
    .qs_bit      (qs_bit),
    .sod_bit     (sod_bit)
  );

  // target reached sources; any of them sets the latch
  assign tgt_set = setpoint_hit
                 | (dsw_qs_opt_ok(qs_option) & qs_done & standstill)
                 | halt_stopped;

  function automatic logic dsw_qs_opt_ok(input logic [15:0] opt);
    dsw_qs_opt_ok = (opt == DSW_QS_OPT_SLOW) || (opt == DSW_QS_OPT_FAST);
  endfunction

  assign warn_now = r.word[DSW_BIT_WARN];

  // next value of every register
  always_comb begin
    next_r = r;
    // state bits and their flags all load in one edge
    next_r.word[DSW_STATE_MSB:0] = state_low;
    next_r.word[DSW_BIT_QS]      = qs_bit;
    next_r.word[DSW_BIT_SOD]     = sod_bit;
    next_r.word[DSW_BIT_VOLT]    = hv_on;
    next_r.word[DSW_BIT_TORQ]    = (load_torque >= torque_limit);
    next_r.word[DSW_BIT_REMOTE]  = remote_en;
    next_r.word[DSW_BIT_LIMIT]   = limit_active;
    // latch clears on a new target, a hit in the same cycle wins
    next_r.tgt_hit = tgt_set | (r.tgt_hit & ~target_chg);
    next_r.word[DSW_BIT_TGT] = next_r.tgt_hit;
    // bit 12 by mode
    if (op_mode == DSW_MODE_PROF_POS) begin
      next_r.word[DSW_BIT_MODE_A] = sp_ack;
    end else if (op_mode == DSW_MODE_HOMING) begin
      next_r.word[DSW_BIT_MODE_A] = homing_done;
    end else if (dsw_mode_is(op_mode, DSW_MODE_CYC_POS, DSW_MODE_CYC_VEL) ||
                 op_mode == DSW_MODE_CYC_TRQ) begin
      next_r.word[DSW_BIT_MODE_A] = follows_cmd;
    end else begin
      next_r.word[DSW_BIT_MODE_A] = 1'b0;
    end
    // bit 13 by mode
    if (dsw_mode_is(op_mode, DSW_MODE_PROF_POS, DSW_MODE_CYC_POS)) begin
      next_r.word[DSW_BIT_MODE_B] = follow_err;
    end else if (op_mode == DSW_MODE_HOMING) begin
      next_r.word[DSW_BIT_MODE_B] = homing_err;
    end else if (op_mode == DSW_MODE_MOTION_SEQ) begin
      next_r.word[DSW_BIT_MODE_B] = seq_err;
    end else begin
      next_r.word[DSW_BIT_MODE_B] = 1'b0;
    end
    // sequence progress only in motion sequence mode
    next_r.word[DSW_BIT_SEQ_GO] = (op_mode == DSW_MODE_MOTION_SEQ) & seq_started;
    next_r.word[DSW_BIT_SEQ_OK] = (op_mode == DSW_MODE_MOTION_SEQ) & seq_finished;
    // warning: held until sent once and then acknowledged, a new one wins
    if (illegal_cw) begin
      next_r.word[DSW_BIT_WARN] = 1'b1;
      next_r.code               = illegal_code;
      next_r.warn_sent          = 1'b0;
    end else if (warn_now) begin
      if (tx_strobe) begin
        next_r.warn_sent = 1'b1;
      end
      if (warn_clr && r.warn_sent) begin
        next_r.word[DSW_BIT_WARN] = 1'b0;
        next_r.warn_sent          = 1'b0;
      end
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      r <= DSW_REGS_RST;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // read-only view of the word and the warning cause
  assign status_word = r.word;
  assign warn_code   = r.code;

  // commands run only when the reported word says remote
  assign cmd_accept = cmd_valid & r.word[DSW_BIT_REMOTE];
  // parameter access and transmission stay open in local mode
  assign sdo_grant  = sdo_req;
  assign tx_allow   = ~sys_rst;

  // legal state patterns of the word
  function automatic logic dsw_legal(input logic [15:0] w);
    logic [2:0] k;
    k = {w[DSW_BIT_SOD], w[DSW_BIT_QS], 1'b0};
    dsw_legal = 1'b0;
    case (w[DSW_STATE_MSB:0])
      DSW_LOW_OFF:         dsw_legal = 1'b1;
      DSW_LOW_READY:       dsw_legal = (k[2:1] == 2'b01);
      DSW_LOW_SWITCHED_ON: dsw_legal = (k[2:1] == 2'b01);
      DSW_LOW_OP_EN:       dsw_legal = ~k[2];
      DSW_LOW_FAULT_REACT: dsw_legal = ~k[2];
      DSW_LOW_FAULT:       dsw_legal = ~k[2];
      default:             dsw_legal = 1'b0;
    endcase
  endfunction

  sequence s_warn_raise;
    ce && illegal_cw ##1 status_word[DSW_BIT_WARN];
  endsequence

  sequence s_qs_stop;
    ce && dsw_qs_opt_ok(qs_option) && qs_done && standstill;
  endsequence

  sequence s_warn_unsent;
    ce && status_word[DSW_BIT_WARN] && !r.warn_sent && warn_clr && !illegal_cw;
  endsequence

  sequence s_warn_sent_clr;
    ce && status_word[DSW_BIT_WARN] && r.warn_sent && warn_clr && !illegal_cw;
  endsequence

  a_state_legal: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dsw_legal(status_word)) else $error("status word state pattern illegal");

  a_not_ready_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && drive_state == DSW_ST_NOT_READY |=>
      status_word[DSW_STATE_MSB:0] == 4'h0 && !status_word[DSW_BIT_SOD])
    else $error("not ready code wrong");

  a_sod_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && drive_state == DSW_ST_SW_ON_DIS |=>
      status_word[DSW_STATE_MSB:0] == 4'h0 && status_word[DSW_BIT_SOD])
    else $error("switch on disabled code wrong");

  a_ready_codes: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && (drive_state == DSW_ST_READY || drive_state == DSW_ST_SWITCHED_ON) |=>
      status_word[6:5] == 2'b01 && status_word[DSW_STATE_MSB:0] ==
      (($past(drive_state) == DSW_ST_READY) ? DSW_LOW_READY : DSW_LOW_SWITCHED_ON))
    else $error("ready or switched on code wrong");

  a_op_en_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && drive_state == DSW_ST_OP_EN |=> status_word[6:0] ==? 7'b01?0111)
    else $error("operation enabled code wrong");

  a_qs_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && drive_state == DSW_ST_QS_ACTIVE |=> status_word[6:0] ==? 7'b00?0111)
    else $error("quick stop active code wrong");

  a_fault_codes: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && (drive_state == DSW_ST_FAULT_REACT || drive_state == DSW_ST_FAULT) |=>
      !status_word[DSW_BIT_SOD] && status_word[DSW_STATE_MSB:0] ==
      (($past(drive_state) == DSW_ST_FAULT) ? DSW_LOW_FAULT : DSW_LOW_FAULT_REACT))
    else $error("fault code wrong");

  a_volt_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce |=> status_word[DSW_BIT_VOLT] == $past(hv_on)) else $error("voltage bit wrong");

  a_warn_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_warn_raise |-> warn_code == $past(illegal_code) ##1
      status_word[DSW_BIT_WARN])
    else $error("warning not held with its code");

  a_torque_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && load_torque >= torque_limit |=> status_word[DSW_BIT_TORQ])
    else $error("torque bit missed");

  a_local_block: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !status_word[DSW_BIT_REMOTE] |-> !cmd_accept && (sdo_grant == sdo_req))
    else $error("local mode gating wrong");

  a_tgt_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_qs_stop or (ce && halt_stopped) |=> status_word[DSW_BIT_TGT])
    else $error("target reached not set at stop");

  a_tgt_change: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && target_chg && !tgt_set |=> !status_word[DSW_BIT_TGT])
    else $error("target reached kept after target change");

  a_mode_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && op_mode == DSW_MODE_HOMING |=>
      status_word[DSW_BIT_MODE_A] == $past(homing_done) &&
      status_word[DSW_BIT_MODE_B] == $past(homing_err))
    else $error("homing flags wrong");

  a_seq_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && op_mode == DSW_MODE_MOTION_SEQ && seq_started && seq_finished |=>
      status_word[DSW_BIT_SEQ_OK:DSW_BIT_SEQ_GO] == 2'b11)
    else $error("sequence flags wrong");

  a_freeze_word: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !ce |=> $stable(status_word) && $stable(warn_code))
    else $error("word moved while frozen");

  a_warn_refuse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_warn_unsent |=> status_word[DSW_BIT_WARN])
    else $error("warning cleared before it was sent");

  a_warn_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_warn_sent_clr |=> !status_word[DSW_BIT_WARN])
    else $error("acknowledged warning not cleared");

  a_code_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && !illegal_cw |=> $stable(warn_code))
    else $error("warning code moved without a warning");

  a_remote_bit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce |=> status_word[DSW_BIT_REMOTE] == $past(remote_en))
    else $error("remote bit wrong");

  a_remote_exec: assert property (@(posedge clk_sys) disable iff (sys_rst)
    status_word[DSW_BIT_REMOTE] |-> cmd_accept == cmd_valid)
    else $error("remote command not accepted");

  a_pp_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && op_mode == DSW_MODE_PROF_POS |=>
      status_word[DSW_BIT_MODE_A] == $past(sp_ack) &&
      status_word[DSW_BIT_MODE_B] == $past(follow_err))
    else $error("profile position flags wrong");

  a_seq_err: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && op_mode == DSW_MODE_MOTION_SEQ |=> status_word[DSW_BIT_MODE_B] == $past(seq_err))
    else $error("sequence error flag wrong");

  a_seq_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && op_mode != DSW_MODE_MOTION_SEQ |=>
      status_word[DSW_BIT_SEQ_OK:DSW_BIT_SEQ_GO] == 2'b00)
    else $error("sequence flags set outside sequence mode");

  a_tgt_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ce && setpoint_hit |=> status_word[DSW_BIT_TGT])
    else $error("target reached not set at setpoint");

endmodule // dsw_status_word

// [logic/dsw_pkg.sv]
// constants and types shared by the drive status word logic
package dsw_pkg;

  // drive state as handed over by the transition logic
  typedef enum logic [2:0] {
    DSW_ST_NOT_READY   = 3'b000,
    DSW_ST_SW_ON_DIS   = 3'b001,
    DSW_ST_READY       = 3'b010,
    DSW_ST_SWITCHED_ON = 3'b011,
    DSW_ST_OP_EN       = 3'b100,
    DSW_ST_QS_ACTIVE   = 3'b101,
    DSW_ST_FAULT_REACT = 3'b110,
    DSW_ST_FAULT       = 3'b111
  } dsw_state_t;

  // active operating mode
  typedef enum logic [3:0] {
    DSW_MODE_CYC_TRQ    = 4'h0,
    DSW_MODE_CYC_VEL    = 4'h1,
    DSW_MODE_CYC_POS    = 4'h2,
    DSW_MODE_HOMING     = 4'h3,
    DSW_MODE_PROF_VEL   = 4'h4,
    DSW_MODE_PROF_POS   = 4'h5,
    DSW_MODE_CUR_REG    = 4'h6,
    DSW_MODE_TRQ_REG    = 4'h7,
    DSW_MODE_VEL_REG    = 4'h8,
    DSW_MODE_POS_REG    = 4'h9,
    DSW_MODE_MOTION_SEQ = 4'ha
  } dsw_mode_t;

  // status word layout
  localparam int unsigned DSW_WORD_W     = 16;
  localparam int unsigned DSW_STATE_MSB  = 3;
  localparam int unsigned DSW_BIT_VOLT   = 4;
  localparam int unsigned DSW_BIT_QS     = 5;
  localparam int unsigned DSW_BIT_SOD    = 6;
  localparam int unsigned DSW_BIT_WARN   = 7;
  localparam int unsigned DSW_BIT_TORQ   = 8;
  localparam int unsigned DSW_BIT_REMOTE = 9;
  localparam int unsigned DSW_BIT_TGT    = 10;
  localparam int unsigned DSW_BIT_LIMIT  = 11;
  localparam int unsigned DSW_BIT_MODE_A = 12;
  localparam int unsigned DSW_BIT_MODE_B = 13;
  localparam int unsigned DSW_BIT_SEQ_GO = 14;
  localparam int unsigned DSW_BIT_SEQ_OK = 15;

  // low nibble state codes
  localparam logic [3:0] DSW_LOW_OFF         = 4'h0;
  localparam logic [3:0] DSW_LOW_READY       = 4'h1;
  localparam logic [3:0] DSW_LOW_SWITCHED_ON = 4'h3;
  localparam logic [3:0] DSW_LOW_OP_EN       = 4'h7;
  localparam logic [3:0] DSW_LOW_FAULT_REACT = 4'hf;
  localparam logic [3:0] DSW_LOW_FAULT       = 4'h8;

  // quick stop option codes that end in target reached
  localparam logic [15:0] DSW_QS_OPT_SLOW = 16'h0005;
  localparam logic [15:0] DSW_QS_OPT_FAST = 16'h0006;

  // reset values
  localparam logic [15:0] DSW_WORD_RST = 16'h0000;
  localparam logic [15:0] DSW_CODE_RST = 16'h0000;

endpackage

// [logic/dsw_state_enc.sv]
// state encoder for the state bits of the drive status word
`timescale 1ns/10ps
module dsw_state_enc
  import dsw_pkg::*;
(
  input  wire dsw_state_t drive_state, // present drive state
  input  wire logic       qs_busy,     // quick stop reaction in progress
  output logic [3:0]      state_low,   // status bits 3..0
  output logic            qs_bit,      // status bit 5
  output logic            sod_bit      // status bit 6
);

  // every state maps to exactly one listed pattern
  always_comb begin
    state_low = DSW_LOW_OFF;
    qs_bit    = ~qs_busy;
    sod_bit   = 1'b0;
    case (drive_state)
      DSW_ST_NOT_READY: begin
        state_low = DSW_LOW_OFF;
      end
      DSW_ST_SW_ON_DIS: begin
        state_low = DSW_LOW_OFF;
        sod_bit   = 1'b1;
      end
      DSW_ST_READY: begin
        state_low = DSW_LOW_READY;
        qs_bit    = 1'b1;
      end
      DSW_ST_SWITCHED_ON: begin
        state_low = DSW_LOW_SWITCHED_ON;
        qs_bit    = 1'b1;
      end
      DSW_ST_OP_EN: begin
        state_low = DSW_LOW_OP_EN;
        qs_bit    = 1'b1;
      end
      DSW_ST_QS_ACTIVE: begin
        state_low = DSW_LOW_OP_EN;
        qs_bit    = 1'b0;
      end
      DSW_ST_FAULT_REACT: begin
        state_low = DSW_LOW_FAULT_REACT;
      end
      DSW_ST_FAULT: begin
        state_low = DSW_LOW_FAULT;
      end
      default: begin
        state_low = DSW_LOW_OFF;
        sod_bit   = 1'b0;
      end
    endcase
  end

endmodule // dsw_state_enc

// [dv/dsw_master_model.sv]
// fieldbus master model that reads and acknowledges the drive status word
`timescale 1ns/10ps
module dsw_master_model (
  input  wire logic        clk_sys,     // system clock
  input  wire logic        sys_rst,     // synchronous reset, active high
  input  wire logic [15:0] status_word, // word offered by the drive
  input  wire logic        tx_allow,    // drive may send process data
  input  wire logic        poll,        // bench asks for one transmission
  input  wire logic        ack,         // bench asks for one warning acknowledge
  output logic             tx_strobe,   // word taken onto the bus
  output logic             warn_clr,    // warning acknowledge pulse
  output logic [15:0]      last_word    // last word seen on the bus
);
  logic pend_p;
  logic pend_a;

  // requests are taken at the rising edge, so no race with the bench
  always @(posedge clk_sys) begin
    pend_p <= poll & tx_allow & !sys_rst;
    pend_a <= ack & !sys_rst;
    if (tx_strobe) begin
      last_word <= status_word;
    end
  end

  // pulses last exactly one cycle, launched off the falling edge, half a cycle after sampling
  always @(negedge clk_sys) begin
    tx_strobe <= pend_p;
    warn_clr  <= pend_a;
  end

  initial begin
    {pend_p, pend_a, tx_strobe, warn_clr} = 4'h0;
    last_word = 16'h0000;
  end
endmodule // dsw_master_model

// [dv/testbench.sv]
// self-checking testbench of the drive status word generator
`timescale 1ns/10ps
module testbench
  import dsw_pkg::*;
;
  logic clk_sys, sys_rst, ce, hv_on, qs_busy, illegal_cw, remote_en, cmd_valid, sdo_req;
  logic setpoint_hit, target_chg, qs_done, standstill, halt_stopped, limit_active, sp_ack;
  logic follows_cmd, homing_done, homing_err, follow_err, seq_err, seq_started, seq_finished;
  logic [15:0] illegal_code, load_torque, torque_limit, qs_option, wc, ew;
  dsw_state_t  drive_state;
  dsw_mode_t   op_mode;
  wire logic   tx_strobe, warn_clr, cmd_accept, sdo_grant, tx_allow;
  wire logic [15:0] status_word, warn_code, last_word;
  logic        poll, ack, w, seen, tg;
  integer      seed = 45425, err_count = 0, samples_checked = 0, cycles = 0;

  dsw_status_word i_dut (.clk_sys, .sys_rst, .ce, .drive_state, .op_mode, .hv_on, .qs_busy,
    .illegal_cw, .illegal_code, .tx_strobe, .warn_clr, .load_torque, .torque_limit,
    .remote_en, .cmd_valid, .sdo_req, .setpoint_hit, .target_chg, .qs_option, .qs_done,
    .standstill, .halt_stopped, .limit_active, .sp_ack, .follows_cmd, .homing_done,
    .homing_err, .follow_err, .seq_err, .seq_started, .seq_finished, .status_word,
    .warn_code, .cmd_accept, .sdo_grant, .tx_allow);

  dsw_master_model i_mst (.clk_sys, .sys_rst, .status_word, .tx_allow, .poll, .ack,
    .tx_strobe, .warn_clr, .last_word);

  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // hang guard
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 10000) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t run did not finish", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // random levels, rare events weighted so every flag toggles
  task automatic rnd();
    {hv_on, qs_busy, remote_en, cmd_valid, sdo_req, qs_done, standstill, limit_active, sp_ack,
     follows_cmd, homing_done, homing_err, follow_err, seq_err, seq_started,
     seq_finished} = 16'($random(seed));
    setpoint_hit = ({$random(seed)} % 4) == 0;
    halt_stopped = ({$random(seed)} % 6) == 0;
    target_chg = 1'($random(seed));
    ce = ({$random(seed)} % 8) != 0;
    illegal_cw = ({$random(seed)} % 16) == 0;
    illegal_code = 16'($random(seed));
    load_torque = 16'({$random(seed)} % 8);
    torque_limit = 16'({$random(seed)} % 8);
    qs_option = 16'h0004 + 16'({$random(seed)} % 4);
    drive_state = dsw_state_t'(3'($random(seed)));
    op_mode = dsw_mode_t'(4'({$random(seed)} % 11));
  endtask

  // expected word from the present levels and the bench's latches
  function automatic logic [15:0] exp_word(input logic wv, input logic tv);
    logic [15:0] x;
    x = 16'h0000;
    case (drive_state)
      DSW_ST_NOT_READY:   x[6:0] = {1'b0, !qs_busy, 5'h00};
      DSW_ST_SW_ON_DIS:   x[6:0] = {1'b1, !qs_busy, 5'h00};
      DSW_ST_READY:       x[6:0] = 7'h21;
      DSW_ST_SWITCHED_ON: x[6:0] = 7'h23;
      DSW_ST_OP_EN:       x[6:0] = 7'h27;
      DSW_ST_QS_ACTIVE:   x[6:0] = 7'h07;
      DSW_ST_FAULT_REACT: x[6:0] = {1'b0, !qs_busy, 5'h0f};
      default:            x[6:0] = {1'b0, !qs_busy, 5'h08};
    endcase
    x[4] = hv_on;
    x[7] = wv;
    x[8] = load_torque >= torque_limit;
    x[9] = remote_en;
    x[10] = tv;
    x[11] = limit_active;
    case (op_mode)
      DSW_MODE_PROF_POS:   x[13:12] = {follow_err, sp_ack};
      DSW_MODE_HOMING:     x[13:12] = {homing_err, homing_done};
      DSW_MODE_CYC_POS:    x[13:12] = {follow_err, follows_cmd};
      DSW_MODE_CYC_TRQ, DSW_MODE_CYC_VEL: x[12] = follows_cmd;
      DSW_MODE_MOTION_SEQ: x[15:13] = {seq_finished, seq_started, seq_err};
      default: ;
    endcase
    return x;
  endfunction

  // follows the edge that has just passed
  task automatic model_tick();
    logic clr;
    logic wn;
    clr = warn_clr & seen;
    wn = illegal_cw | (w & !clr);
    if (sys_rst) begin
      {w, seen, tg} = 3'h0;
      wc = 16'h0000;
      ew = 16'h0000;
    end else if (ce) begin
      // a new warning must be sent again before it may be cleared
      seen = !illegal_cw & wn & (seen | (w & tx_strobe));
      w = wn;
      if (illegal_cw) wc = illegal_code;
      tg = setpoint_hit | halt_stopped | (tg & !target_chg) |
           ((qs_option == 16'h0005 || qs_option == 16'h0006) & qs_done & standstill);
      ew = exp_word(w, tg);
    end
  endtask

  // one cycle: check the word, then drive the next inputs
  task automatic step(input bit r);
    @(negedge clk_sys);
    model_tick();
    chk(status_word, ew, "status word");
    chk(warn_code, wc, "warning code");
    if (r) rnd();
    poll = 1'b0;
    ack = 1'b0;
    #1;
    chk({13'h0, cmd_accept, sdo_grant, tx_allow},
        {13'h0, cmd_valid & ew[9], sdo_req, !sys_rst}, "grants");
  endtask

  initial begin
    {poll, ack, w, seen, tg} = 5'h0;
    wc = 16'h0000;
    ew = 16'h0000;
    rnd();
    sys_rst = 1'b1;
    repeat (20) step(0);
    sys_rst = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      rnd();
      {ce, illegal_cw} = 2'b10;
      drive_state = dsw_state_t'(3'(i));
      qs_busy = i[3];
      step(0);
    end
    $display("test state table done");
    illegal_cw = 1'b1;
    illegal_code = 16'h5a3c;
    step(0);
    illegal_cw = 1'b0;
    ack = 1'b1;
    repeat (3) step(0);
    chk({15'h0, status_word[7]}, 16'h0001, "clear before send");
    poll = 1'b1;
    repeat (3) step(0);
    ack = 1'b1;
    repeat (3) step(0);
    chk({15'h0, status_word[7]}, 16'h0000, "clear after send");
    chk({15'h0, last_word[7]}, 16'h0001, "sent warning");
    $display("test warning done");
    repeat (3000) step(1);
    $display("test random done");
    sys_rst = 1'b1;
    repeat (2) step(1);
    sys_rst = 1'b0;
    repeat (200) step(1);
    $display("test second reset done");
    stop_test();
  end
endmodule // testbench
